// *** logic/ulprb_pkg.sv ***
package ulprb_pkg;

	// Immediate register addresses
	localparam logic [5:0] ADR_MAKER_LO   = 6'h00;
	localparam logic [5:0] ADR_MAKER_HI   = 6'h01;
	localparam logic [5:0] ADR_PART_LO    = 6'h02;
	localparam logic [5:0] ADR_PART_HI    = 6'h03;
	localparam logic [5:0] ADR_FUNC       = 6'h04;
	localparam logic [5:0] ADR_IFC        = 6'h07;
	localparam logic [5:0] ADR_DUAL       = 6'h0a;
	localparam logic [5:0] ADR_EN_RISE    = 6'h0d;
	localparam logic [5:0] ADR_EN_FALL    = 6'h10;
	localparam logic [5:0] ADR_EV_STATE   = 6'h13;
	localparam logic [5:0] ADR_EV_LATCH   = 6'h14;
	localparam logic [5:0] ADR_DEBUG      = 6'h15;
	localparam logic [5:0] ADR_SCRATCH    = 6'h16;
	localparam logic [5:0] ADR_CAR        = 6'h19;
	localparam logic [5:0] ADR_ESCAPE     = 6'h2f;
	localparam logic [5:0] ADR_POWER      = 6'h3d;
	localparam logic [7:0] EXT_LIMIT      = 8'h40;

	// Identity bytes, arbitrary values
	localparam logic [7:0] ID_MAKER_LO    = 8'h5a;
	localparam logic [7:0] ID_MAKER_HI    = 8'h01;
	localparam logic [7:0] ID_PART_LO     = 8'h23;
	localparam logic [7:0] ID_PART_HI     = 8'h00;

	// Reset values
	localparam logic [7:0] RST_FUNC       = 8'h41;
	localparam logic [7:0] RST_IFC        = 8'h00;
	localparam logic [7:0] RST_DUAL       = 8'h06;
	localparam logic [7:0] RST_EN         = 8'h1f;
	localparam logic [7:0] RST_POWER      = 8'h0a;
	localparam logic [7:0] RST_ZERO       = 8'h00;

	// Function-control fields
	localparam int F_SPD_LO   = 0;
	localparam int F_TERM     = 2;
	localparam int F_ENC_LO   = 3;
	localparam int F_RESET    = 5;
	localparam int F_SUSP_N   = 6;
	// Interface-control fields
	localparam int I_SER6     = 0;
	localparam int I_SER3     = 1;
	localparam int I_CARKIT   = 2;
	localparam int I_CLK_ON   = 3;
	localparam int I_AUTORES  = 4;
	localparam int I_INVERT   = 5;
	localparam int I_UNQUAL   = 6;
	localparam int I_PROT_DIS = 7;
	// Dual-role fields
	localparam int D_DP_PD    = 1;
	localparam int D_DM_PD    = 2;
	// Power-control fields
	localparam int P_OC_OFF   = 1;
	localparam int P_UART_SWP = 2;
	localparam int P_UART_LV  = 3;
	localparam logic [7:0] P_RSVD_MASK = 8'hf1;

	// Speed and encoding codes
	localparam logic [1:0] SPD_HS   = 2'h0;
	localparam logic [1:0] SPD_FS   = 2'h1;
	localparam logic [1:0] SPD_LS   = 2'h2;
	localparam logic [1:0] SPD_FSLS = 2'h3;
	localparam logic [1:0] ENC_NORM = 2'h0;
	localparam logic [1:0] ENC_NDRV = 2'h1;

	// Access kind from low address offset
	typedef enum logic [1:0] {
		ULPRB_WR,
		ULPRB_SET,
		ULPRB_CLR
	} ulprb_op_t;

	// Timing
	localparam int CLK_MHZ     = 200;
	localparam int CAL_NS      = 2000;
	localparam int CAL_CYC     = (CAL_NS * CLK_MHZ) / 1000;
	localparam int CORE_RST_NS = 500;
	localparam int CORE_RST_CYC = (CORE_RST_NS * CLK_MHZ + 999) / 1000;
	localparam int GAP_CYC     = 1;

endpackage

// *** logic/ulprb_bank.sv ***
// Operation
// RULE_01: Write address replaces all register bits with bus data.
// RULE_02: Set address ORs bus data into the register.
// RULE_03: Clear address zeroes register bits where bus data has ones.
// RULE_04: Control register at base/base+1/base+2 write/set/clear; all read back.
// RULE_05: Escape opens 8-bit space; 00-3F alias immediates, 40-FF reserved.
// RULE_06: Four constant read-only identity bytes at addresses 00 to 03.
// RULE_07: Power bit 1 turns overload detector off when one; resets one.
// RULE_08: Power bit 2 swaps UART pins; bit 3 selects low UART voltage.
// RULE_09: Link never writes ones to power bits 0 and 7 to 4.
// RULE_10: Speed field 00 HS, 01 FS reset, 10 LS, 11 FS with preamble.
// RULE_11: Changing speed to 00 stops the output clock during calibration.
// RULE_12: Termination bit effect depends on speed, encoding and pull-downs.
// RULE_13: Encoding field 00 normal, 01 non-driving, 10 no stuff, 11 raw HS.
// RULE_14: Reset bit asserts DIR, resets core, drops DIR, self-clears, sends RX CMD.
// RULE_15: Core reset keeps register contents and does not restart the PLL.
// RULE_16: Reset with suspend in one access enters low power, reset cleared.
// RULE_17: Active-low suspend; zero enters low power, set again on exit.
// RULE_18: Interface bits 0,1 select serial modes; cleared on serial exit.
// RULE_19: Interface bit 2 enables car-kit mode offering UART only.
// RULE_20: Interface bit 3 keeps clock on in serial modes; ignored while suspended.
// RULE_21: Interface bit 4 reserved, no auto-resume behaviour.
// RULE_22: Bit 5 inverts external VBUS flag; bit 6 skips VbusValid qualification.
// RULE_23: Bit 7 zero enables data pull-downs and STP pull-up protection.
module ulprb_bank
	import ulprb_pkg::*;
#(
	parameter int CAL_CYCLES  = CAL_CYC,
	parameter int CORE_CYCLES = CORE_RST_CYC
) (
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rstn_i,
	// Register access from the ULPI protocol engine
	input  wire logic       acc_wr_i,
	input  wire logic       acc_rd_i,
	input  wire logic       acc_ext_i,
	input  wire logic [5:0] acc_addr_i,
	input  wire logic [7:0] acc_ext_addr_i,
	input  wire logic [7:0] acc_wdata_i,
	output logic      [7:0] acc_rdata_o,
	output logic            acc_rvalid_o,
	// Status from analog and link side
	input  wire logic       ext_vbus_flag_in_i,
	input  wire logic       vbus_valid_i,
	input  wire logic [4:0] event_src_i,
	input  wire logic [1:0] line_state_i,
	input  wire logic       low_power_exit_i,
	input  wire logic       serial_exit_i,
	input  wire logic       cal_done_i,
	// Transceiver controls
	output logic      [1:0] transceiver_speed_select_o,
	output logic      [1:0] transmit_encoding_mode_o,
	output logic            low_power_o,
	output logic            serial_fsls_6pin_o,
	output logic            serial_fsls_3pin_o,
	output logic            carkit_uart_o,
	output logic            serial_clock_keep_on_o,
	output logic            overload_detector_off_o,
	output logic            uart_swap_o,
	output logic            uart_low_voltage_sel_o,
	output logic            rpu_dp_en_o,
	output logic            rpu_dm_en_o,
	output logic            rpd_dp_en_o,
	output logic            rpd_dm_en_o,
	output logic            hsterm_en_o,
	output logic            data_pulldown_guard_o,
	output logic            stp_pullup_guard_o,
	output logic            ext_vbus_state_o,
	// Clock stop and core reset
	output logic            ulpi_clk_stop_o,
	output logic            core_reset_o,
	output logic            dir_force_o,
	output logic            rxcmd_req_o
);

	typedef enum logic [1:0] {
		ULPRB_IDLE,
		ULPRB_CORE,
		ULPRB_GAP
	} ulprb_rst_t;

	typedef struct packed {
		logic [7:0]  func;
		logic [7:0]  ifc;
		logic [7:0]  dual;
		logic [7:0]  en_rise;
		logic [7:0]  en_fall;
		logic [7:0]  latch;
		logic [7:0]  scratch;
		logic [7:0]  car;
		logic [7:0]  power;
		logic [4:0]  src_prev;
		logic [7:0]  rdata;
		logic        rvalid;
		logic [15:0] cal_cnt;
		logic        cal_on;
		ulprb_rst_t  rst_st;
		logic [15:0] rst_cnt;
		logic        rxcmd;
	} ulprb_state_t;

	ulprb_state_t st_ff;
	ulprb_state_t nxt_st;

	// Bus-facing outputs come from registers of the same clock domain
	function automatic logic [7:0] apply_op(input logic [7:0] cur, input logic [7:0] d,
		input logic [1:0] k);
		logic [7:0] r;
		r = cur;
		unique case (k)
			2'd0: r = d;          // RULE_01
			2'd1: r = cur | d;    // RULE_02
			2'd2: r = cur & ~d;   // RULE_03
			default: r = cur;
		endcase
		return r;
	endfunction

	// Does address hit the triplet at base
	function automatic logic hit3(input logic [5:0] a, input logic [5:0] base);
		return (a >= base) && (a <= base + 6'd2);
	endfunction

	logic [5:0] eff_addr;
	logic       eff_ok;
	logic [1:0] kind;
	logic [4:0] rise_ev;
	logic [4:0] fall_ev;
	logic [4:0] sticky_set;
	logic       vbus_ind;

	always_comb begin
		if (acc_ext_i) begin
			eff_ok   = acc_ext_addr_i < EXT_LIMIT;            // RULE_05
			eff_addr = acc_ext_addr_i[5:0];                   // RULE_05
		end else begin
			eff_ok   = 1'b1;
			eff_addr = acc_addr_i;
		end
	end

	assign rise_ev    = event_src_i & ~st_ff.src_prev;
	assign fall_ev    = ~event_src_i & st_ff.src_prev;
	assign sticky_set = (rise_ev & st_ff.en_rise[4:0]) | (fall_ev & st_ff.en_fall[4:0]);
	assign vbus_ind   = ext_vbus_flag_in_i ^ st_ff.ifc[I_INVERT];   // RULE_22

	always_comb begin
		logic [7:0] f_new;
		logic [5:0] base;
		f_new  = st_ff.func;
		base   = 6'h00;
		kind   = 2'd3;
		nxt_st = st_ff;
		nxt_st.rvalid   = 1'b0;
		nxt_st.rxcmd    = 1'b0;
		nxt_st.src_prev = event_src_i;
		nxt_st.latch    = st_ff.latch | {3'b000, sticky_set};

		// Calibration clock stop; a new HS entry below restarts it
		if (st_ff.cal_on) begin
			nxt_st.cal_cnt = st_ff.cal_cnt + 16'd1;
			if (cal_done_i || st_ff.cal_cnt >= 16'(CAL_CYCLES - 1))
				nxt_st.cal_on = 1'b0;                             // RULE_11
		end

		// Triplet decoding: offset within the triplet gives the kind
		if (hit3(eff_addr, ADR_FUNC)) base = ADR_FUNC;
		else if (hit3(eff_addr, ADR_IFC)) base = ADR_IFC;
		else if (hit3(eff_addr, ADR_DUAL)) base = ADR_DUAL;
		else if (hit3(eff_addr, ADR_EN_RISE)) base = ADR_EN_RISE;
		else if (hit3(eff_addr, ADR_EN_FALL)) base = ADR_EN_FALL;
		else if (hit3(eff_addr, ADR_SCRATCH)) base = ADR_SCRATCH;
		else if (hit3(eff_addr, ADR_CAR)) base = ADR_CAR;
		else if (hit3(eff_addr, ADR_POWER)) base = ADR_POWER;
		kind = 2'(eff_addr - base);                             // RULE_04

		if (acc_wr_i && eff_ok && (base != 6'h00 || eff_addr == ADR_FUNC)) begin
			unique case (base)
				ADR_FUNC: begin
					f_new = apply_op(st_ff.func, acc_wdata_i, kind);
					if (f_new[F_RESET] && !f_new[F_SUSP_N])
						f_new[F_RESET] = 1'b0;                     // RULE_16
					nxt_st.func = f_new;
					if (f_new[1:0] == SPD_HS && st_ff.func[1:0] != SPD_HS) begin
						nxt_st.cal_on  = 1'b1;                     // RULE_11
						nxt_st.cal_cnt = '0;
					end
				end
				ADR_IFC:     nxt_st.ifc     = apply_op(st_ff.ifc, acc_wdata_i, kind); // RULE_21
				ADR_DUAL:    nxt_st.dual    = apply_op(st_ff.dual, acc_wdata_i, kind);
				ADR_EN_RISE: nxt_st.en_rise = apply_op(st_ff.en_rise, acc_wdata_i, kind);
				ADR_EN_FALL: nxt_st.en_fall = apply_op(st_ff.en_fall, acc_wdata_i, kind);
				ADR_SCRATCH: nxt_st.scratch = apply_op(st_ff.scratch, acc_wdata_i, kind);
				ADR_CAR:     nxt_st.car     = apply_op(st_ff.car, acc_wdata_i, kind);
				ADR_POWER:   nxt_st.power   = apply_op(st_ff.power, acc_wdata_i, kind);
				default: ;
			endcase
		end

		if (acc_rd_i) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata  = RST_ZERO;
			if (eff_ok) begin
				unique case (eff_addr)
					ADR_MAKER_LO: nxt_st.rdata = ID_MAKER_LO;      // RULE_06
					ADR_MAKER_HI: nxt_st.rdata = ID_MAKER_HI;      // RULE_06
					ADR_PART_LO:  nxt_st.rdata = ID_PART_LO;       // RULE_06
					ADR_PART_HI:  nxt_st.rdata = ID_PART_HI;       // RULE_06
					ADR_EV_STATE: nxt_st.rdata = {3'b000, event_src_i};
					ADR_EV_LATCH: begin
						nxt_st.rdata = st_ff.latch | {3'b000, sticky_set};
						// Events arriving this cycle stay latched
						nxt_st.latch = {3'b000, sticky_set};
					end
					ADR_DEBUG:    nxt_st.rdata = {6'h00, line_state_i};
					default: begin
						unique case (base)
							ADR_FUNC:    nxt_st.rdata = st_ff.func;     // RULE_04
							ADR_IFC:     nxt_st.rdata = st_ff.ifc;
							ADR_DUAL:    nxt_st.rdata = st_ff.dual;
							ADR_EN_RISE: nxt_st.rdata = st_ff.en_rise;
							ADR_EN_FALL: nxt_st.rdata = st_ff.en_fall;
							ADR_SCRATCH: nxt_st.rdata = st_ff.scratch;
							ADR_CAR:     nxt_st.rdata = st_ff.car;
							ADR_POWER:   nxt_st.rdata = st_ff.power;
							default:     nxt_st.rdata = RST_ZERO;
						endcase
					end
				endcase
			end
		end

		// Core reset sequence; register contents untouched except the reset bit
		unique case (st_ff.rst_st)
			ULPRB_IDLE: begin
				if (st_ff.func[F_RESET] && st_ff.func[F_SUSP_N]) begin
					nxt_st.rst_st  = ULPRB_CORE;                   // RULE_14
					nxt_st.rst_cnt = '0;
				end
			end
			ULPRB_CORE: begin
				nxt_st.rst_cnt = st_ff.rst_cnt + 16'd1;
				if (st_ff.rst_cnt >= 16'(CORE_CYCLES - 1)) begin
					nxt_st.rst_st = ULPRB_GAP;
					nxt_st.func[F_RESET] = 1'b0;                  // RULE_14
				end
			end
			ULPRB_GAP: begin
				nxt_st.rst_st = ULPRB_IDLE;
				nxt_st.rxcmd  = 1'b1;                            // RULE_14
			end
		endcase

		// Hardware events override software in the same cycle
		if (low_power_exit_i && !st_ff.func[F_SUSP_N])
			nxt_st.func[F_SUSP_N] = 1'b1;                        // RULE_17
		if (serial_exit_i) begin
			nxt_st.ifc[I_SER6] = 1'b0;                           // RULE_18
			nxt_st.ifc[I_SER3] = 1'b0;                           // RULE_18
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			st_ff <= '{func: RST_FUNC, ifc: RST_IFC, dual: RST_DUAL, en_rise: RST_EN,
				en_fall: RST_EN, power: RST_POWER, rst_st: ULPRB_IDLE, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// =====================================================================
	// Control outputs
	logic [1:0] spd;
	logic [1:0] enc;
	logic       term;
	logic       dp_pd;
	logic       dm_pd;
	assign spd   = st_ff.func[F_SPD_LO +: 2];
	assign enc   = st_ff.func[F_ENC_LO +: 2];
	assign term  = st_ff.func[F_TERM];
	assign dp_pd = st_ff.dual[D_DP_PD];
	assign dm_pd = st_ff.dual[D_DM_PD];

	assign acc_rdata_o                = st_ff.rdata;
	assign acc_rvalid_o               = st_ff.rvalid;
	assign transceiver_speed_select_o = spd;                 // RULE_10
	assign transmit_encoding_mode_o   = enc;                 // RULE_13
	assign low_power_o                = ~st_ff.func[F_SUSP_N];   // RULE_17
	assign serial_fsls_6pin_o         = st_ff.ifc[I_SER6];   // RULE_18
	assign serial_fsls_3pin_o         = st_ff.ifc[I_SER3];   // RULE_18
	assign carkit_uart_o              = st_ff.ifc[I_CARKIT]; // RULE_19
	// Auto-resume bit stored only, drives nothing
	assign serial_clock_keep_on_o     = st_ff.ifc[I_CLK_ON] & st_ff.func[F_SUSP_N]; // RULE_20
	assign overload_detector_off_o    = st_ff.power[P_OC_OFF];   // RULE_07
	assign uart_swap_o                = st_ff.power[P_UART_SWP]; // RULE_08
	assign uart_low_voltage_sel_o     = st_ff.power[P_UART_LV];  // RULE_08
	assign ext_vbus_state_o = st_ff.ifc[I_UNQUAL] ? vbus_ind : (vbus_ind & vbus_valid_i); // RULE_22

	// Termination matrix
	always_comb begin
		logic host;
		host        = dp_pd & dm_pd;
		rpd_dp_en_o = dp_pd;                                                 // RULE_12
		rpd_dm_en_o = dm_pd;                                                 // RULE_12
		rpu_dp_en_o = 1'b0;
		rpu_dm_en_o = 1'b0;
		hsterm_en_o = 1'b0;
		if (enc != ENC_NDRV) begin
			if (spd == SPD_HS) begin
				hsterm_en_o = ~term;                                         // RULE_12
				rpu_dp_en_o = term & ~host;                                  // RULE_12
			end else if (term && !host) begin
				rpu_dp_en_o = (spd != SPD_LS);                               // RULE_12
				rpu_dm_en_o = (spd == SPD_LS);                               // RULE_12
			end
		end
	end

	assign data_pulldown_guard_o = ~st_ff.ifc[I_PROT_DIS] | (st_ff.rst_st == ULPRB_CORE); // RULE_23
	assign stp_pullup_guard_o    = ~st_ff.ifc[I_PROT_DIS];                               // RULE_23
	assign ulpi_clk_stop_o       = st_ff.cal_on;                                          // RULE_11
	assign core_reset_o          = (st_ff.rst_st == ULPRB_CORE);                          // RULE_15
	assign dir_force_o           = (st_ff.rst_st == ULPRB_CORE) | st_ff.rxcmd;           // RULE_14
	assign rxcmd_req_o           = st_ff.rxcmd;                                           // RULE_14

	// =====================================================================
	// Assertions
	AST_WRITE: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_01
		acc_wr_i && !acc_ext_i && acc_addr_i == ADR_SCRATCH
		|=> st_ff.scratch == $past(acc_wdata_i)) else $error("scratch write lost");
	AST_SET: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_02
		acc_wr_i && !acc_ext_i && acc_addr_i == ADR_SCRATCH + 6'd1
		|=> st_ff.scratch == ($past(st_ff.scratch) | $past(acc_wdata_i)))
		else $error("set wrong");
	AST_CLEAR: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_03
		acc_wr_i && !acc_ext_i && acc_addr_i == ADR_SCRATCH + 6'd2
		|=> st_ff.scratch == ($past(st_ff.scratch) & ~$past(acc_wdata_i)))
		else $error("clear wrong");
	AST_ID: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_06
		acc_rd_i && !acc_ext_i && acc_addr_i == ADR_MAKER_LO
		|=> acc_rvalid_o && acc_rdata_o == ID_MAKER_LO) else $error("id wrong");
	AST_EXT_RSVD: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_05
		acc_rd_i && acc_ext_i && acc_ext_addr_i >= EXT_LIMIT
		|=> acc_rdata_o == RST_ZERO) else $error("reserved ext read");
	AST_CAL: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_11
		$rose(ulpi_clk_stop_o) |-> transceiver_speed_select_o == SPD_HS)
		else $error("clock stop without HS");
	AST_RST_SEQ: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_14
		$fell(core_reset_o) |-> !dir_force_o ##1 (dir_force_o && rxcmd_req_o))
		else $error("reset sequence wrong");
	AST_SUSP: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_16
		low_power_o |-> !core_reset_o ##0 !serial_clock_keep_on_o)
		else $error("suspend priority wrong");
	AST_PROT: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_23
		!st_ff.ifc[I_PROT_DIS] |-> data_pulldown_guard_o && stp_pullup_guard_o)
		else $error("protection off");
	AST_TRIPLET_RD: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_04
		acc_rd_i && !acc_ext_i && acc_addr_i == ADR_SCRATCH + 6'd2
		|=> acc_rvalid_o && acc_rdata_o == $past(st_ff.scratch)) else $error("triplet read wrong");
	AST_SUSP_RST: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_16
		acc_wr_i && !acc_ext_i && acc_addr_i == ADR_FUNC && !low_power_exit_i
		&& acc_wdata_i[F_RESET] && !acc_wdata_i[F_SUSP_N]
		|=> low_power_o && !st_ff.func[F_RESET]) else $error("reset kept under suspend");
	AST_LP_EXIT: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_17
		low_power_exit_i && low_power_o |=> !low_power_o) else $error("suspend not released");
	AST_SER_EXIT: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_18
		serial_exit_i |=> !serial_fsls_6pin_o && !serial_fsls_3pin_o)
		else $error("serial mode kept");
	AST_PROT_WR: assert property (@(posedge mclk_i) disable iff (!rstn_i) // RULE_23
		acc_wr_i && !acc_ext_i && acc_addr_i == ADR_IFC && !acc_wdata_i[I_PROT_DIS]
		|=> data_pulldown_guard_o && stp_pullup_guard_o) else $error("protection not restored");

endmodule

// *** verification/ulprb_link_model.sv ***
module ulprb_link_model
	import ulprb_pkg::*;
(
	// Clock
	input  wire logic       mclk_i,
	// Register access toward the bank
	output logic            acc_wr_o,
	output logic            acc_rd_o,
	output logic            acc_ext_o,
	output logic      [5:0] acc_addr_o,
	output logic      [7:0] acc_ext_addr_o,
	output logic      [7:0] acc_wdata_o,
	input  wire logic [7:0] acc_rdata_i,
	input  wire logic       acc_rvalid_i
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle cycles before each access, raised to act as a slow link
	int gap = 0;

	initial begin
		acc_wr_o       = 1'b0;
		acc_rd_o       = 1'b0;
		acc_ext_o      = 1'b0;
		acc_addr_o     = 6'h00;
		acc_ext_addr_o = 8'h00;
		acc_wdata_o    = 8'h00;
	end

	// =========================================
	// One access: held up to the taking edge
	task automatic acc(input logic w, input logic x, input logic [7:0] a,
			input logic [7:0] d, output logic [7:0] q);
		logic [7:0] m;
		m = d;
		if (w && (a[5:0] == ADR_POWER || a[5:0] == ADR_POWER + 6'h01)) begin
			m = d & ~P_RSVD_MASK;
		end
		repeat (gap) @(posedge mclk_i);
		@(posedge mclk_i);
		acc_wr_o       <= w;
		acc_rd_o       <= !w;
		acc_ext_o      <= x;
		acc_addr_o     <= a[5:0];
		acc_ext_addr_o <= a;
		acc_wdata_o    <= m;
		@(posedge mclk_i);
		acc_wr_o       <= 1'b0;
		acc_rd_o       <= 1'b0;
		acc_addr_o     <= ~a[5:0];
		acc_ext_addr_o <= ~a;
		acc_wdata_o    <= ~m;
		q = 8'h00;
		if (!w) begin
			// Answer stands for one cycle: take it at the edge that closes it
			@(posedge mclk_i);
			q = (acc_rvalid_i === 1'b1) ? acc_rdata_i : 8'hxx;
		end
	endtask
endmodule

// *** verification/test_ulpi_phy_register_bank.sv ***
module test_ulpi_phy_register_bank
	import ulprb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int CAL  = 8;
	localparam int CORE = 4;

	logic       mclk_i   = 1'b0;
	logic       rstn_i   = 1'b0;
	logic       ext_flag = 1'b1;
	logic       vb_valid = 1'b0;
	logic [4:0] ev_src   = 5'h00;
	logic [1:0] line_st  = 2'h0;
	logic       lp_exit  = 1'b0;
	logic       ser_exit = 1'b0;
	logic       cal_done = 1'b0;
	logic       wr, rd, ext, rvalid;
	logic [5:0] addr;
	logic [7:0] ext_addr, wdata, rdata, q;
	logic [1:0] speed, enc;
	logic       low_pwr, ser6, ser3, carkit, keep_on, ovl, swap, lv;
	logic       rpu_dp, rpu_dm, rpd_dp, rpd_dm, hsterm, dguard, sguard;
	logic       vbus_st, clk_stop, core_rst, dir_f, rxcmd;
	int         fail_count = 0;
	int         n_compared = 0;
	int         n;

	always #2.5 mclk_i = ~mclk_i;

	ulprb_link_model u_link (.mclk_i(mclk_i), .acc_wr_o(wr), .acc_rd_o(rd),
		.acc_ext_o(ext), .acc_addr_o(addr), .acc_ext_addr_o(ext_addr),
		.acc_wdata_o(wdata), .acc_rdata_i(rdata), .acc_rvalid_i(rvalid));

	ulprb_bank #(.CAL_CYCLES(CAL), .CORE_CYCLES(CORE)) u_ulprb_bank (
		.mclk_i(mclk_i), .rstn_i(rstn_i), .acc_wr_i(wr), .acc_rd_i(rd),
		.acc_ext_i(ext), .acc_addr_i(addr), .acc_ext_addr_i(ext_addr),
		.acc_wdata_i(wdata), .acc_rdata_o(rdata), .acc_rvalid_o(rvalid),
		.ext_vbus_flag_in_i(ext_flag), .vbus_valid_i(vb_valid),
		.event_src_i(ev_src), .line_state_i(line_st), .low_power_exit_i(lp_exit),
		.serial_exit_i(ser_exit), .cal_done_i(cal_done),
		.transceiver_speed_select_o(speed), .transmit_encoding_mode_o(enc),
		.low_power_o(low_pwr), .serial_fsls_6pin_o(ser6), .serial_fsls_3pin_o(ser3),
		.carkit_uart_o(carkit), .serial_clock_keep_on_o(keep_on),
		.overload_detector_off_o(ovl), .uart_swap_o(swap), .uart_low_voltage_sel_o(lv),
		.rpu_dp_en_o(rpu_dp), .rpu_dm_en_o(rpu_dm), .rpd_dp_en_o(rpd_dp),
		.rpd_dm_en_o(rpd_dm), .hsterm_en_o(hsterm), .data_pulldown_guard_o(dguard),
		.stp_pullup_guard_o(sguard), .ext_vbus_state_o(vbus_st),
		.ulpi_clk_stop_o(clk_stop), .core_reset_o(core_rst), .dir_force_o(dir_f),
		.rxcmd_req_o(rxcmd));

	// =========================================
	// Helpers
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic wa(input logic x, input logic [7:0] a, input logic [7:0] d);
		u_link.acc(1'b1, x, a, d, q);
		#1;
	endtask

	task automatic rc(input logic x, input logic [7:0] a, input logic [7:0] e);
		u_link.acc(1'b0, x, a, 8'h00, q);
		chk(q, e);
	endtask

	task automatic pulse(input int k);
		@(posedge mclk_i);
		lp_exit  <= (k == 0);
		ser_exit <= (k == 1);
		cal_done <= (k == 2);
		@(posedge mclk_i);
		lp_exit  <= 1'b0;
		ser_exit <= 1'b0;
		cal_done <= 1'b0;
	endtask

	function automatic logic pick(input bit s);
		return s ? (core_rst & dir_f) : clk_stop;
	endfunction

	// Length of the next high run of clock stop or core reset
	task automatic run_len(input bit s, output int k);
		k = 0;
		for (int i = 0; i < 4 && pick(s) !== 1'b1; i++) begin
			@(posedge mclk_i);
			#1;
		end
		while (pick(s) === 1'b1 && k < 60) begin
			k++;
			@(posedge mclk_i);
			#1;
		end
	endtask

	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		#60000;
		fail_count++;
		summarize();
	end

	// =========================================
	// Tests
	initial begin
		logic [7:0] ids [4] = '{ID_MAKER_LO, ID_MAKER_HI, ID_PART_LO, ID_PART_HI};
		logic [7:0] fv [4]  = '{8'h40, 8'h40, 8'h45, 8'h4d};
		logic [7:0] dv [4]  = '{8'h06, 8'h00, 8'h00, 8'h06};
		logic [4:0] tv [4]  = '{5'h07, 5'h01, 5'h10, 5'h06};
		repeat (2) @(posedge mclk_i);
		rstn_i <= 1'b1;
		#1;
		for (int i = 0; i < 4; i++) rc(0, 8'(i), ids[i]);
		wa(0, 8'h00, 8'hff);
		rc(0, 8'h00, ID_MAKER_LO);
		for (int i = 4; i < 7; i++) rc(0, 8'(i), RST_FUNC);
		rc(0, 8'h07, RST_IFC);
		rc(0, 8'h3f, RST_POWER);
		chk({speed, ovl, swap, lv, dguard, sguard, low_pwr}, 8'h6e);
		$display("test reset done");
		wa(0, 8'h16, 8'ha5);
		rc(0, 8'h16, 8'ha5);
		wa(0, 8'h17, 8'h0f);
		rc(0, 8'h17, 8'haf);
		wa(0, 8'h18, 8'h21);
		rc(0, 8'h18, 8'h8e);
		rc(1, 8'h16, 8'h8e);
		wa(1, 8'h16, 8'h33);
		rc(0, 8'h16, 8'h33);
		wa(1, 8'h40, 8'hff);
		rc(1, 8'h40, 8'h00);
		rc(0, 8'h1c, 8'h00);
		$display("test access done");
		for (int i = 0; i < 4; i++) begin
			wa(0, 8'h04, 8'h40 | 8'(i));
			chk({6'h00, speed}, 8'(i));
			wa(0, 8'h04, 8'h41 | 8'(i << 3));
			chk({6'h00, enc}, 8'(i));
		end
		wa(0, 8'h04, 8'h41);
		wa(0, 8'h04, 8'h40);
		run_len(0, n);
		chk(8'(n), 8'(CAL));
		wa(0, 8'h04, 8'h41);
		wa(0, 8'h04, 8'h40);
		pulse(2);
		repeat (2) @(posedge mclk_i);
		#1;
		chk({7'h00, clk_stop}, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wa(0, 8'h0a, dv[i]);
			wa(0, 8'h04, fv[i]);
			chk({3'h0, rpu_dp, rpu_dm, rpd_dp, rpd_dm, hsterm}, {3'h0, tv[i]});
		end
		$display("test speed done");
		wa(0, 8'h16, 8'h3c);
		wa(0, 8'h04, 8'h41);
		wa(0, 8'h05, 8'h20);
		run_len(1, n);
		chk(8'(n), 8'(CORE));
		chk({7'h00, dir_f}, 8'h00);
		@(posedge mclk_i);
		#1;
		chk({6'h00, rxcmd, dir_f}, 8'h03);
		rc(0, 8'h04, 8'h41);
		rc(0, 8'h16, 8'h3c);
		wa(0, 8'h04, 8'h21);
		@(posedge mclk_i);
		#1;
		chk({6'h00, low_pwr, core_rst}, 8'h02);
		rc(0, 8'h04, 8'h01);
		pulse(0);
		rc(0, 8'h04, 8'h41);
		$display("test core reset done");
		wa(0, 8'h07, 8'h0b);
		chk({5'h00, ser6, ser3, keep_on}, 8'h07);
		wa(0, 8'h06, 8'h40);
		chk({6'h00, keep_on, low_pwr}, 8'h01);
		wa(0, 8'h05, 8'h40);
		pulse(1);
		rc(0, 8'h07, 8'h08);
		wa(0, 8'h08, 8'h04);
		chk({7'h00, carkit}, 8'h01);
		wa(0, 8'h08, 8'h80);
		chk({6'h00, dguard, sguard}, 8'h00);
		rc(0, 8'h09, 8'h8c);
		for (int i = 0; i < 4; i++) begin
			wa(0, 8'h07, 8'(i << 5));
			chk({7'h00, vbus_st}, {7'h00, i == 2});
		end
		@(posedge mclk_i);
		ext_flag <= 1'b0;
		vb_valid <= 1'b1;
		wa(0, 8'h07, 8'h20);
		chk({7'h00, vbus_st}, 8'h01);
		$display("test interface done");
		wa(0, 8'h3e, 8'h04);
		chk({5'h00, ovl, swap, lv}, 8'h07);
		wa(0, 8'h3f, 8'h0a);
		chk({5'h00, ovl, swap, lv}, 8'h02);
		u_link.gap = 3;
		wa(1, 8'h3d, 8'hff);
		rc(0, 8'h3d, 8'h0e);
		@(posedge mclk_i);
		ev_src  <= 5'h15;
		line_st <= 2'h2;
		rc(0, 8'h13, 8'h15);
		rc(0, 8'h15, 8'h02);
		rc(0, 8'h14, 8'h15);
		rc(0, 8'h14, 8'h00);
		$display("test power and status done");
		summarize();
	end
endmodule
